// *** verilog/motor_stop_and_demag_control.v ***
// motor stop sequencer, brake pin handling and active demag gate control with AXI4-Lite registers
// assumes the commutation controller shares aclk; comparators and brake pin arrive asynchronously
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "motor_stop_regs.vh"

// Operation
// - demag on: fet turns on when diode conducts
// - each bridge has high and low comparators
// - commutation current flows through complementary fet
// - mode 000: all six fets off at once
// - mode 001: partial off, recirculate, then off
// - high-side modulation: high off, low kept
// - low-side modulation: low off, high kept
// - mode 010: slow down, low-side brake, off
// - mode 011: slow down, high-side brake, off
// - below threshold: brake without slowing down
// - brake pin: slow down, then low-side brake
// - pin brake lasts until pin goes low
// - mode 100: lower duty, then all off
module motor_stop_and_demag_control (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        stop_request,
  input  wire [7:0]  speed_duty,
  input  wire        highside_modulation,
  input  wire [2:0]  drive_hs,
  input  wire [2:0]  drive_ls,
  input  wire [2:0]  highside_negcurrent_comparator,
  input  wire [2:0]  lowside_negcurrent_comparator,
  input  wire        brake_pin,
  output wire [2:0]  phase_output_hs,
  output wire [2:0]  phase_output_ls,
  output wire        duty_reduce,
  output wire [7:0]  duty_target
);

  localparam S_RUN        = 3'd0;
  localparam S_RECIRC     = 3'd1;
  localparam S_REDUCE     = 3'd2;
  localparam S_BRAKE      = 3'd3;
  localparam S_HIZ        = 3'd4;
  localparam S_PIN_REDUCE = 3'd5;
  localparam S_PIN_BRAKE  = 3'd6;

  localparam [31:0] TICK_LAST_W  = `BRAKE_TICK_CYC - 1;
  localparam [9:0]  TICK_LAST    = TICK_LAST_W[9:0];
  localparam [31:0] RECIRC_LSB_W = `RECIRC_LSB_CYC;
  localparam [15:0] RECIRC_LSB   = RECIRC_LSB_W[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // register storage and AXI4-Lite slave

  reg        awready_q;
  reg        wready_q;
  reg        bvalid_q;
  reg [1:0]  bresp_q;
  reg        arready_q;
  reg        rvalid_q;
  reg [1:0]  rresp_q;
  reg [31:0] rdata_q;
  reg        aw_full_q;
  reg [3:0]  aw_addr_q;
  reg        w_full_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;

  reg [3:0]  ctrl_q;
  reg [7:0]  spin_thr_q;
  reg [7:0]  pin_thr_q;
  reg [15:0] brk_time_q;

  reg [2:0]  state_q;
  reg [2:0]  state_d;
  reg [2:0]  mode_q;
  reg [2:0]  gate_hs_q;
  reg [2:0]  gate_ls_q;
  wire       brake_sync;

  wire       wr_fire;
  wire       wr_hit;
  wire       rd_fire;
  reg [31:0] rd_mux;
  reg        rd_hit;

  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign wr_hit  = (aw_addr_q == `CTRL_OFFSET) || (aw_addr_q == `THRESH_OFFSET) ||
                   (aw_addr_q == `BRKTIME_OFFSET) || (aw_addr_q == `STATUS_OFFSET);
  assign rd_fire = s_axi_arvalid && arready_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      aw_full_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_full_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (!awready_q && !aw_full_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (!wready_q && !w_full_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (s_axi_awvalid && awready_q) begin
        aw_addr_q <= s_axi_awaddr;
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // writable fields; status is read only and ignores writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= `CTRL_RESET;
      spin_thr_q <= `SPIN_THR_RESET;
      pin_thr_q  <= `PIN_THR_RESET;
      brk_time_q <= `BRKTIME_RESET;
    end else if (wr_fire) begin
      if (aw_addr_q == `CTRL_OFFSET && w_strb_q[0]) begin
        ctrl_q <= w_data_q[3:0];
      end
      if (aw_addr_q == `THRESH_OFFSET) begin
        if (w_strb_q[0]) begin
          spin_thr_q <= w_data_q[`THRESH_SPIN_MSB:`THRESH_SPIN_LSB];
        end
        if (w_strb_q[1]) begin
          pin_thr_q <= w_data_q[`THRESH_PIN_MSB:`THRESH_PIN_LSB];
        end
      end
      if (aw_addr_q == `BRKTIME_OFFSET) begin
        if (w_strb_q[0]) begin
          brk_time_q[7:0] <= w_data_q[7:0];
        end
        if (w_strb_q[1]) begin
          brk_time_q[15:8] <= w_data_q[15:8];
        end
      end
    end
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `CTRL_OFFSET:    rd_mux[3:0]   = ctrl_q;
      `THRESH_OFFSET:  rd_mux[15:0]  = {pin_thr_q, spin_thr_q};
      `BRKTIME_OFFSET: rd_mux[15:0]  = brk_time_q;
      `STATUS_OFFSET:  rd_mux[12:0]  = {brake_sync, gate_ls_q, gate_hs_q, mode_q, state_q};
      default:         rd_hit        = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= `RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else begin
      if (!arready_q && !rvalid_q) begin
        arready_q <= 1'b1;
      end
      if (rd_fire) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_mux;
        rresp_q   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and per-bridge demag merge

  wire [2:0] hs_cmp_sync;
  wire [2:0] ls_cmp_sync;
  wire [2:0] demag_hs;
  wire [2:0] demag_ls;

  sync2 #(.W(7)) u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({brake_pin, lowside_negcurrent_comparator, highside_negcurrent_comparator}),
    .dout    ({brake_sync, ls_cmp_sync, hs_cmp_sync})
  );

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_bridge
      half_bridge_demag u_demag (
        .enable   (ctrl_q[`CTRL_DEMAG_BIT]),
        .drive_hs (drive_hs[g]),
        .drive_ls (drive_ls[g]),
        .hs_cmp   (hs_cmp_sync[g]),
        .ls_cmp   (ls_cmp_sync[g]),
        .gate_hs  (demag_hs[g]),
        .gate_ls  (demag_ls[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // stop sequencer

  reg        hs_mod_q;
  reg [2:0]  held_hs_q;
  reg [2:0]  held_ls_q;
  reg [15:0] cnt_q;
  reg [9:0]  tick_q;
  reg [2:0]  gate_hs_d;
  reg [2:0]  gate_ls_d;
  reg        reduce_q;
  reg [7:0]  target_q;

  wire [2:0]  mode_sel  = ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  wire        below_thr = speed_duty <= spin_thr_q;
  wire        below_pin = speed_duty <= pin_thr_q;
  wire [15:0] recirc_n  = {8'h00, speed_duty} * RECIRC_LSB;
  wire        tick_end  = tick_q == TICK_LAST;

  always @* begin
    state_d = state_q;
    case (state_q)
      S_RUN: begin
        if (brake_sync) begin
          state_d = S_PIN_REDUCE;
        end else if (stop_request) begin
          case (mode_sel)
            `MODE_RECIRC:    state_d = S_RECIRC;
            `MODE_LS_BRAKE,
            `MODE_HS_BRAKE:  state_d = below_thr ? S_BRAKE : S_REDUCE;
            `MODE_SPIN_DOWN: state_d = below_thr ? S_HIZ : S_REDUCE;
            default:         state_d = S_HIZ;
          endcase
        end
      end
      S_RECIRC: if (cnt_q == 16'h0000) state_d = S_HIZ;
      S_REDUCE: begin
        if (below_thr) begin
          state_d = (mode_q == `MODE_SPIN_DOWN) ? S_HIZ : S_BRAKE;
        end
      end
      S_BRAKE: if (cnt_q >= brk_time_q) state_d = S_HIZ;
      S_HIZ: if (!stop_request) state_d = S_RUN;
      S_PIN_REDUCE: begin
        if (!brake_sync) begin
          state_d = S_RUN;
        end else if (below_pin) begin
          state_d = S_PIN_BRAKE;
        end
      end
      S_PIN_BRAKE: if (!brake_sync) state_d = S_RUN;
      default: state_d = S_HIZ;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q   <= S_RUN;
      mode_q    <= `MODE_COAST;
      hs_mod_q  <= 1'b0;
      held_hs_q <= 3'h0;
      held_ls_q <= 3'h0;
      cnt_q     <= 16'h0000;
      tick_q    <= 10'h000;
    end else begin
      state_q <= state_d;
      if (state_q == S_RUN && stop_request && !brake_sync) begin
        mode_q    <= mode_sel;
        hs_mod_q  <= highside_modulation;
        held_hs_q <= drive_hs;
        held_ls_q <= drive_ls;
        // only recirculation preloads; a direct brake must start counting from zero
        cnt_q     <= (mode_sel == `MODE_RECIRC) ? recirc_n : 16'h0000;
      end else if (state_q == S_RECIRC && cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end else if (state_q == S_BRAKE) begin
        if (tick_end) begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end else begin
        cnt_q <= 16'h0000;
      end
      tick_q <= (state_q != S_BRAKE || tick_end) ? 10'h000 : tick_q + 10'h001;
    end
  end

  always @* begin
    gate_hs_d = 3'h0;
    gate_ls_d = 3'h0;
    case (state_d)
      S_RUN, S_REDUCE, S_PIN_REDUCE: begin
        gate_hs_d = demag_hs;
        gate_ls_d = demag_ls;
      end
      S_RECIRC: begin
        if ((state_q == S_RUN) ? highside_modulation : hs_mod_q) begin
          gate_ls_d = (state_q == S_RUN) ? drive_ls : held_ls_q;
        end else begin
          gate_hs_d = (state_q == S_RUN) ? drive_hs : held_hs_q;
        end
      end
      S_BRAKE: begin
        if ((state_q == S_RUN ? mode_sel : mode_q) == `MODE_HS_BRAKE) begin
          gate_hs_d = 3'h7;
        end else begin
          gate_ls_d = 3'h7;
        end
      end
      S_PIN_BRAKE: gate_ls_d = 3'h7;
      default: begin
        gate_hs_d = 3'h0;
        gate_ls_d = 3'h0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      gate_hs_q <= 3'h0;
      gate_ls_q <= 3'h0;
      reduce_q  <= 1'b0;
      target_q  <= 8'h00;
    end else begin
      gate_hs_q <= gate_hs_d;
      gate_ls_q <= gate_ls_d;
      reduce_q  <= (state_d == S_REDUCE) || (state_d == S_PIN_REDUCE);
      target_q  <= (state_d == S_PIN_REDUCE) ? pin_thr_q : spin_thr_q;
    end
  end

  assign s_axi_awready   = awready_q;
  assign s_axi_wready    = wready_q;
  assign s_axi_bvalid    = bvalid_q;
  assign s_axi_bresp     = bresp_q;
  assign s_axi_arready   = arready_q;
  assign s_axi_rvalid    = rvalid_q;
  assign s_axi_rresp     = rresp_q;
  assign s_axi_rdata     = rdata_q;
  assign phase_output_hs = gate_hs_q;
  assign phase_output_ls = gate_ls_q;
  assign duty_reduce     = reduce_q;
  assign duty_target     = target_q;

endmodule // motor_stop_and_demag_control

// *** pkg/motor_stop_regs.vh ***
// register offsets, fields, reset values, mode codes and timing of the stop and demag block
// assumes a 10 MHz aclk and a 32-bit AXI4-Lite register port with 4-bit byte addresses
`ifndef MOTOR_STOP_REGS_VH
`define MOTOR_STOP_REGS_VH

`define CTRL_OFFSET        4'h0
`define THRESH_OFFSET      4'h4
`define BRKTIME_OFFSET     4'h8
`define STATUS_OFFSET      4'hC

`define CTRL_DEMAG_BIT     0
`define CTRL_MODE_LSB      1
`define CTRL_MODE_MSB      3
`define THRESH_SPIN_LSB    0
`define THRESH_SPIN_MSB    7
`define THRESH_PIN_LSB     8
`define THRESH_PIN_MSB     15
`define BRKTIME_LSB        0
`define BRKTIME_MSB        15

`define CTRL_RESET         4'h0
`define SPIN_THR_RESET     8'h20
`define PIN_THR_RESET      8'h10
`define BRKTIME_RESET      16'h0064

`define MODE_COAST         3'h0
`define MODE_RECIRC        3'h1
`define MODE_LS_BRAKE      3'h2
`define MODE_HS_BRAKE      3'h3
`define MODE_SPIN_DOWN     3'h4

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`define CLK_PERIOD_NS      100
`define BRAKE_TICK_NS      100000
`define BRAKE_TICK_CYC     ((`BRAKE_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECIRC_LSB_NS      2000
`define RECIRC_LSB_CYC     ((`RECIRC_LSB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** verilog/sync2.v ***
// two flip-flop synchroniser for a bus of independent levels
// assumes each bit is a slow level from outside the aclk domain
`timescale 1ns/1ps

module sync2 #(
  parameter W = 1
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule // sync2

// *** verilog/half_bridge_demag.v ***
// active demagnetization gate merge for one half-bridge
// assumes commutation commands and synchronised comparator levels on aclk
`timescale 1ns/1ps

module half_bridge_demag (
  input  wire enable,
  input  wire drive_hs,
  input  wire drive_ls,
  input  wire hs_cmp,
  input  wire ls_cmp,
  output wire gate_hs,
  output wire gate_ls
);

  wire want_hs;
  wire want_ls;

  // a tripped comparator means its own fet's body diode conducts
  assign want_hs = drive_hs | (enable & hs_cmp & ~drive_ls);
  assign want_ls = drive_ls | (enable & ls_cmp & ~drive_hs);

  // never both fets of one bridge unless both are commanded; fall back to the plain command
  assign gate_hs = (want_hs & want_ls) ? drive_hs : want_hs;
  assign gate_ls = (want_hs & want_ls) ? drive_ls : want_ls;

endmodule // half_bridge_demag

// *** testbench/motor_stop_assertions.sv ***
// port-level checks of the stop sequencer and brake handling
// assumes bind to the top module; a ctrl write offers address and data together
`timescale 1ns/1ps

module motor_stop_assertions (
  input wire        aclk,
  input wire        aresetn,
  input wire [3:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        stop_request,
  input wire [7:0]  speed_duty,
  input wire        highside_modulation,
  input wire [2:0]  drive_hs,
  input wire [2:0]  drive_ls,
  input wire        brake_pin,
  input wire [2:0]  phase_output_hs,
  input wire [2:0]  phase_output_ls,
  input wire        duty_reduce,
  input wire [7:0]  duty_target
);
  reg [2:0] mode_q;
  wire      wr_ctrl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 4'h0;

  // shadow of the selected stop mode
  always @(posedge aclk) begin
    if (!aresetn)
      mode_q <= 3'h0;
    else if (wr_ctrl && s_axi_wstrb[0])
      mode_q <= s_axi_wdata[3:1];
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////////
  coast_all_off_a: assert property ($rose(stop_request) && (mode_q == 3'h0 || mode_q > 3'h4)
    |=> phase_output_hs == 3'h0 && phase_output_ls == 3'h0) else $error("gates left on after coast stop");
  recirc_hs_off_a: assert property ($rose(stop_request) && mode_q == 3'h1 && highside_modulation
    |=> phase_output_hs == 3'h0 && phase_output_ls == $past(drive_ls)) else $error("bad low-side recirculation");
  recirc_ls_off_a: assert property ($rose(stop_request) && mode_q == 3'h1 && !highside_modulation
    |=> phase_output_ls == 3'h0 && phase_output_hs == $past(drive_hs)) else $error("bad high-side recirculation");
  reduce_start_a: assert property ($rose(stop_request) && mode_q > 3'h1 && mode_q < 3'h5
    && speed_duty > duty_target |=> duty_reduce) else $error("no speed reduction on stop");
  reduce_end_a: assert property (duty_reduce && speed_duty <= duty_target
    |-> ##[1:2] !duty_reduce) else $error("speed reduction does not end at threshold");
  brake_enter_a: assert property ($rose(stop_request) && mode_q[2:1] == 2'h1 && speed_duty <= duty_target
    |=> phase_output_ls == {3{~mode_q[0]}} && phase_output_hs == {3{mode_q[0]}}) else $error("no direct brake");
  spin_down_end_a: assert property (duty_reduce && mode_q == 3'h4 && stop_request && !brake_pin
    && speed_duty <= duty_target |-> ##[1:2] (phase_output_hs == 3'h0 && phase_output_ls == 3'h0))
    else $error("spin-down does not end in hi-z");
  pin_brake_hold_a: assert property (phase_output_ls == 3'h7 && phase_output_hs == 3'h0 && brake_pin
    && $past(brake_pin, 3) && !stop_request |=> phase_output_ls == 3'h7) else $error("pin brake released early");
endmodule // motor_stop_assertions

// *** testbench/bridge_model.sv ***
// three half-bridges: negative-current comparator levels per phase
// assumes the bench sets the winding current direction per phase
`timescale 1ns/1ps

module bridge_model (
  input  wire [2:0] gate_hs,
  input  wire [2:0] gate_ls,
  input  wire [2:0] flow_up,
  input  wire [2:0] flow_down,
  output wire [2:0] hs_cmp,
  output wire [2:0] ls_cmp
);
  // current toward supply trips the high comparator unless the low fet clamps the phase
  assign hs_cmp = flow_up & ~gate_ls;
  assign ls_cmp = flow_down & ~gate_hs;
endmodule // bridge_model

// *** testbench/testbench.sv ***
// self-checking bench: register bus, stop modes, brake pin and demag
// assumes bridge_model and motor_stop_assertions are compiled alongside
`timescale 1ns/1ps
`include "motor_stop_regs.vh"

module testbench;
  reg         aclk, aresetn, awv, wv, bready, arv, rready, stop, hmod, brake;
  reg  [3:0]  awaddr, araddr, strb;
  reg  [31:0] wdata, q;
  reg  [7:0]  speed;
  reg  [2:0]  dhs, dls, up, down;
  reg  [1:0]  r;
  wire        awready, wready, bvalid, arready, rvalid, dred;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [2:0]  ghs, gls, hcmp, lcmp;
  wire [7:0]  dtgt;
  wire        on = |{ghs, gls};
  integer     failures, n_compared, n, m;

  motor_stop_and_demag_control i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .stop_request(stop), .speed_duty(speed), .highside_modulation(hmod),
    .drive_hs(dhs), .drive_ls(dls), .highside_negcurrent_comparator(hcmp), .lowside_negcurrent_comparator(lcmp),
    .brake_pin(brake), .phase_output_hs(ghs), .phase_output_ls(gls), .duty_reduce(dred), .duty_target(dtgt));

  bridge_model i_bridge (.gate_hs(ghs), .gate_ls(gls), .flow_up(up), .flow_down(down), .hs_cmp(hcmp), .ls_cmp(lcmp));

  always #50 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask

  task cyc(input integer k);
    repeat (k) @(posedge aclk);
  endtask

  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      while (awv || wv) begin
        @(posedge aclk);
        if (awready) awv <= 1'b0;
        if (wready) wv <= 1'b0;
      end
      while (!bvalid) @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
    end
  endtask

  task rd(input [3:0] a);
    begin
      @(posedge aclk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (arready) arv <= 1'b0;
      end while (!rvalid);
      q = rdata;
      r = rresp;
      rready <= 1'b0;
    end
  endtask

  // cycles until every gate is off
  task span;
    begin
      n = 0;
      while (on === 1'b1 && n < 3000) begin
        @(posedge aclk);
        n = n + 1;
      end
    end
  endtask

  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    n_compared = 0;
    {aclk, aresetn, awv, wv, bready, arv, rready, stop, hmod, brake} = 10'h000;
    {awaddr, araddr, wdata, strb} = {8'h00, 32'h0000_0000, 4'hf};
    {speed, dhs, dls, up, down} = {8'h05, 3'h1, 3'h4, 6'h00};
    cyc(16);
    aresetn <= 1'b1;
    cyc(2);
    rd(4'h0);
    chk(q, 32'h0000_0000);
    rd(4'h4);
    chk(q, 32'h0000_1020);
    rd(4'h8);
    chk(q, 32'h0000_0064);
    rd(4'h2);
    chk(r, 2'h2);
    chk(q, 32'h0000_0000);
    wr(4'h2, 32'h0000_000e);
    chk(r, 2'h2);
    strb <= 4'h2;
    wr(4'h4, 32'h0000_3355);
    rd(4'h4);
    chk(q, 32'h0000_3320);
    strb <= 4'hf;
    wr(4'h4, 32'h0000_1020);
    wr(4'h8, 32'h0000_0001);
    wr(4'hc, 32'hffff_ffff);
    chk(r, 2'h0);
    $display("test registers done");
    for (m = 5; m < 9; m = m + 1) begin
      wr(4'h0, (m & 7) << 1);
      stop <= 1'b1;
      cyc(3);
      chk({ghs, gls}, 6'h00);
      rd(4'hc);
      chk(q, (m & 7) * 8 + 4);
      stop <= 1'b0;
      cyc(3);
    end
    chk({ghs, gls}, 6'h0c);
    $display("test coast done");
    wr(4'h0, 32'h0000_0002);
    for (m = 0; m < 2; m = m + 1) begin
      hmod <= m[0];
      cyc(1);
      stop <= 1'b1;
      cyc(2);
      chk({ghs, gls}, m ? 6'h04 : 6'h08);
      span;
      chk(n > 96 && n < 104, 1);
      stop <= 1'b0;
      cyc(3);
    end
    $display("test recirculation done");
    wr(4'h0, 32'h0000_0004);
    speed <= 8'h40;
    stop <= 1'b1;
    cyc(3);
    chk({dred, dtgt}, 9'h120);
    wr(4'h0, 32'h0000_0006);
    speed <= 8'h20;
    cyc(4);
    chk({dred, ghs, gls}, 7'h07);
    span;
    chk(n > `BRAKE_TICK_CYC - 12 && n < `BRAKE_TICK_CYC + 4, 1);
    stop <= 1'b0;
    cyc(3);
    speed <= 8'h10;
    cyc(1);
    stop <= 1'b1;
    cyc(2);
    chk({dred, ghs, gls}, 7'h38);
    span;
    chk(n > `BRAKE_TICK_CYC - 4 && n < `BRAKE_TICK_CYC + 4, 1);
    stop <= 1'b0;
    $display("test braking done");
    wr(4'h0, 32'h0000_0008);
    speed <= 8'h40;
    stop <= 1'b1;
    cyc(3);
    chk(dred, 1'b1);
    speed <= 8'h18;
    cyc(4);
    chk({dred, ghs, gls}, 7'h00);
    stop <= 1'b0;
    speed <= 8'h40;
    cyc(3);
    $display("test spin-down done");
    brake <= 1'b1;
    cyc(5);
    chk({dred, dtgt}, 9'h110);
    speed <= 8'h10;
    cyc(4);
    chk({dred, ghs, gls}, 7'h07);
    cyc(2000);
    chk(gls, 3'h7);
    brake <= 1'b0;
    cyc(5);
    chk({ghs, gls}, 6'h0c);
    $display("test brake pin done");
    wr(4'h0, 32'h0000_0001);
    dhs <= 3'h2;
    down <= 3'h1;
    cyc(5);
    chk({ghs, gls}, 6'h15);
    down <= 3'h0;
    up <= 3'h1;
    cyc(7);
    chk({ghs, gls}, 6'h1c);
    wr(4'h0, 32'h0000_0000);
    cyc(4);
    chk({ghs, gls}, 6'h14);
    $display("test demag done");
    finish_test;
  end

  initial begin
    cyc(20000);
    failures = failures + 1;
    finish_test;
  end
endmodule // testbench

bind motor_stop_and_demag_control motor_stop_assertions i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .stop_request(stop_request),
  .speed_duty(speed_duty), .highside_modulation(highside_modulation), .drive_hs(drive_hs),
  .drive_ls(drive_ls), .brake_pin(brake_pin), .phase_output_hs(phase_output_hs),
  .phase_output_ls(phase_output_ls), .duty_reduce(duty_reduce), .duty_target(duty_target));
